// file: verilog/emb_defs.svh
// Register offsets, field positions, reset values and codes for the bus.
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH
`define EMB_OFF_MSS     16'hFFF0
`define EMB_OFF_BEM     16'hFFF8
`define EMB_OFF_STAT    16'hFFE0
`define EMB_BEM_RESET   8'h10
`define EMB_MSS_RESET   8'hC8
`define EMB_BEM_MASK    8'h37
`define EMB_MSS_MASK    8'hEF
`define EMB_MODE_MSB    2
`define EMB_MODE_LSB    0
`define EMB_WAIT_MSB    5
`define EMB_WAIT_LSB    4
`define EMB_ROM_MSB     3
`define EMB_ROM_LSB     0
`define EMB_RAM_MSB     7
`define EMB_RAM_LSB     5
`define EMB_MODE_SC_IN  3'h0
`define EMB_MODE_SC_OUT 3'h1
`define EMB_MODE_W256   3'h3
`define EMB_MODE_W4K    3'h4
`define EMB_MODE_W16K   3'h5
`define EMB_MODE_FULL   3'h7
`define EMB_WAIT_NONE   2'h0
`define EMB_WAIT_ONE    2'h1
`define EMB_WAIT_EXT    2'h3
`define EMB_ROM_60K     4'hF
`define EMB_ROM60_TOP   16'hF400
`define EMB_RAM_1K      3'h6
`define EMB_RAM_1K_SIZE 16'h0400
`define EMB_RAM_HS_SIZE 16'h0200
`define EMB_SFR_BASE    16'hFF00
`define EMB_RESV_BASE   16'hF800
`define EMB_WIN_256     16'h0100
`define EMB_WIN_4K      16'h1000
`define EMB_WIN_16K     16'h4000
`define EMB_P5_4K       8'h0F
`define EMB_P5_16K      8'h3F
`define EMB_P5_FULL     8'hFF
`define EMB_P6_BUS_OE   8'hB0
`define EMB_P6_WAIT_BIT 6
`define EMB_RESP_OKAY   2'h0
`define EMB_RESP_SLVERR 2'h2
`endif

// file: verilog/emb_pkg.sv
// Types shared by the expansion bus controller.
package emb_pkg;
  typedef enum logic [3:0] {
    EMB_IDLE = 4'b0001,
    EMB_ADDR = 4'b0010,
    EMB_STRB = 4'b0100,
    EMB_END  = 4'b1000
  } emb_phase_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emb_cpu_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } emb_cpu_rsp_t;

  typedef struct packed {
    emb_phase_t  phase;
    logic        ext;
    logic        fetch;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        waitCnt;
    logic        rdN;
    logic        wrN;
    logic        address_latch_strobe;
    logic        cpuAck;
    logic [7:0]  cpuRdata;
    logic [7:0]  mss;
    logic [7:0]  bem;
    logic        awHeld;
    logic [15:0] awAddr;
    logic        wHeld;
    logic [7:0]  wData;
    logic        wStrb0;
    logic        awReady;
    logic        wReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [7:0]  rData;
    logic [1:0]  rResp;
    logic [7:0]  p4Out;
    logic [7:0]  p4Oe;
    logic [7:0]  p5Out;
    logic [7:0]  p5Oe;
    logic [7:0]  p6Out;
    logic [7:0]  p6Oe;
  } emb_state_t;
endpackage

// file: verilog/emb_addr_decode.sv
// Decides whether a CPU address falls in the external expansion window.
`timescale 1ns/1ns
`include "emb_defs.svh"
module emb_addr_decode
#(
  parameter logic [15:0] RESV_BASE = `EMB_RESV_BASE
)
(
  // Access address.
  input  wire logic [15:0] addr,
  // Configuration.
  input  wire logic [2:0]  mode,
  input  wire logic [3:0]  romCode,
  input  wire logic [2:0]  ramCode,
  // Result.
  output logic             isExt
);
  import emb_pkg::*;

  // The 60 Kbyte setting also blocks the 1 Kbyte just above the ROM.
  function automatic logic [15:0] romTop(input logic [3:0] code);
    romTop = (code == `EMB_ROM_60K) ? `EMB_ROM60_TOP : {code, 12'h000};
  endfunction

  logic [15:0] top;
  logic [15:0] span;
  logic [15:0] ramBase;
  logic [15:0] lim;
  logic        above;

  always_comb
  begin
    top     = romTop(romCode);
    span    = addr - top;
    ramBase = `EMB_SFR_BASE - ((ramCode == `EMB_RAM_1K) ?
              `EMB_RAM_1K_SIZE : `EMB_RAM_HS_SIZE);
    lim     = (ramBase < RESV_BASE) ? ramBase : RESV_BASE;
    above   = (addr >= top) && (addr < lim);
    unique case (mode)
      `EMB_MODE_W256: isExt = above && (span < `EMB_WIN_256);
      `EMB_MODE_W4K:  isExt = above && (span < `EMB_WIN_4K);
      `EMB_MODE_W16K: isExt = above && (span < `EMB_WIN_16K);
      `EMB_MODE_FULL: isExt = above;
      default:        isExt = 1'b0;
    endcase
  end
endmodule // emb_addr_decode

// file: verilog/emb_bus_ctrl.sv
// Multiplexed external memory expansion bus controller with its registers.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "emb_defs.svh"
module emb_bus_ctrl
#(
  parameter logic [7:0]  MSS_RESET = `EMB_MSS_RESET,
  parameter logic [15:0] RESV_BASE = `EMB_RESV_BASE
)
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Register write channels.
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [15:0]           awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  // Register read channels.
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [15:0]           araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  // CPU access port.
  input  wire emb_pkg::emb_cpu_req_t cpuReq,
  output emb_pkg::emb_cpu_rsp_t      cpuRsp,
  // Port latches used while a pin is in port mode.
  input  wire logic [7:0]            portLat4,
  input  wire logic [7:0]            portLat5,
  input  wire logic [7:0]            portDir5,
  input  wire logic [7:0]            portLat6,
  input  wire logic [7:0]            portDir6,
  // Pins.
  input  wire logic [7:0]            pin4In,
  input  wire logic [7:0]            pin6In,
  output logic [7:0]                 pin4Out,
  output logic [7:0]                 pin4Oe,
  output logic [7:0]                 pin5Out,
  output logic [7:0]                 pin5Oe,
  output logic [7:0]                 pin6Out,
  output logic [7:0]                 pin6Oe
);
  import emb_pkg::*;

  localparam emb_state_t RST_ST = '{
    phase: EMB_IDLE, rdN: 1'b1, wrN: 1'b1, bem: `EMB_BEM_RESET,
    mss: MSS_RESET, awReady: 1'b1, wReady: 1'b1, arReady: 1'b1,
    default: '0};

  emb_state_t st;
  emb_state_t next_st;
  logic       decExt;
  logic       expOn;
  logic       extWait;
  logic [2:0] mode;
  logic [1:0] waitSel;
  logic [7:0] p5Mask;
  logic [7:0] p6Mask;
  logic [7:0] p6Bus;

  // Register select: 1 size, 2 mode, 3 status, 0 unmapped.
  function automatic logic [1:0] regSel(input logic [15:0] a);
    logic [15:0] w;
    w = {a[15:2], 2'b00};
    if (w == `EMB_OFF_MSS)
      regSel = 2'h1;
    else if (w == `EMB_OFF_BEM)
      regSel = 2'h2;
    else if (w == `EMB_OFF_STAT)
      regSel = 2'h3;
    else
      regSel = 2'h0;
  endfunction

  function automatic logic isExpMode(input logic [2:0] m);
    isExpMode = (m == `EMB_MODE_W256) || (m == `EMB_MODE_W4K) ||
                (m == `EMB_MODE_W16K) || (m == `EMB_MODE_FULL);
  endfunction

  assign mode    = st.bem[`EMB_MODE_MSB:`EMB_MODE_LSB];
  assign waitSel = st.bem[`EMB_WAIT_MSB:`EMB_WAIT_LSB];
  assign expOn   = isExpMode(mode);
  assign extWait = (waitSel == `EMB_WAIT_EXT);

  emb_addr_decode #(
    .RESV_BASE (RESV_BASE)
  ) u_decode (
    .addr      (cpuReq.addr),
    .mode      (mode),
    .romCode   (st.mss[`EMB_ROM_MSB:`EMB_ROM_LSB]),
    .ramCode   (st.mss[`EMB_RAM_MSB:`EMB_RAM_LSB]),
    .isExt     (decExt)
  );

  always_comb
  begin
    next_st = st;
    next_st.cpuAck = 1'b0;
    // Register writes: address and data taken in either order.
    if (awvalid && st.awReady)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wReady)
    begin
      next_st.wHeld  = 1'b1;
      next_st.wData  = wdata[7:0];
      next_st.wStrb0 = wstrb[0];
    end
    if (bready && st.bValid)
      next_st.bValid = 1'b0;
    if (next_st.awHeld && next_st.wHeld && !st.bValid)
    begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = `EMB_RESP_OKAY;
      unique case (regSel(next_st.awAddr))
        2'h1:
          if (next_st.wStrb0)
            next_st.mss = next_st.wData & `EMB_MSS_MASK;
        2'h2:
          if (next_st.wStrb0)
            next_st.bem = next_st.wData & `EMB_BEM_MASK;
        2'h3: next_st.bResp = `EMB_RESP_OKAY;
        2'h0: next_st.bResp = `EMB_RESP_SLVERR;
      endcase
    end
    next_st.awReady = !next_st.awHeld && !next_st.bValid;
    next_st.wReady  = !next_st.wHeld && !next_st.bValid;
    // Register reads.
    if (rready && st.rValid)
      next_st.rValid = 1'b0;
    if (arvalid && st.arReady)
    begin
      next_st.rValid = 1'b1;
      next_st.rResp  = `EMB_RESP_OKAY;
      unique case (regSel(araddr))
        2'h1: next_st.rData = st.mss;
        2'h2: next_st.rData = st.bem;
        2'h3: next_st.rData = {5'h00, st.phase == EMB_STRB && st.rdN
                               && st.wrN && st.ext, st.ext,
                               st.phase != EMB_IDLE};
        2'h0:
        begin
          next_st.rData = 8'h00;
          next_st.rResp = `EMB_RESP_SLVERR;
        end
      endcase
    end
    next_st.arReady = !next_st.rValid;
    // Bus cycle sequencer; each CPU access is one full cycle.
    unique case (st.phase)
      EMB_IDLE:
        if (cpuReq.valid)
        begin
          next_st.phase = EMB_ADDR;
          next_st.ext   = decExt && expOn;
          next_st.fetch = cpuReq.fetch;
          next_st.write = cpuReq.write && !cpuReq.fetch;
          next_st.addr  = cpuReq.addr;
          next_st.wdata = cpuReq.wdata;
          next_st.address_latch_strobe  = 1'b1;
        end
      EMB_ADDR:
      begin
        next_st.phase   = EMB_STRB;
        next_st.address_latch_strobe    = 1'b0;
        next_st.waitCnt = (waitSel == `EMB_WAIT_ONE);
        next_st.rdN     = !(st.ext && !st.write);
        next_st.wrN     = !(st.ext && st.write);
      end
      EMB_STRB:
        if (st.waitCnt)
          next_st.waitCnt = 1'b0;
        else if (st.ext && extWait && !pin6In[`EMB_P6_WAIT_BIT])
          next_st.phase = EMB_STRB;
        else
        begin
          next_st.phase    = EMB_END;
          next_st.rdN      = 1'b1;
          next_st.wrN      = 1'b1;
          next_st.cpuAck   = 1'b1;
          next_st.cpuRdata = (st.ext && !st.write) ? pin4In : 8'h00;
        end
      EMB_END: next_st.phase = EMB_IDLE;
      default: next_st.phase = EMB_IDLE;
    endcase
    // Pin multiplexing follows the next phase so pins align with it.
    if (expOn)
    begin
      next_st.p4Out = (next_st.phase == EMB_STRB) ? next_st.wdata
                                                 : next_st.addr[7:0];
      next_st.p4Oe  = {8{next_st.phase == EMB_ADDR ||
                        (next_st.phase == EMB_STRB && next_st.write &&
                         next_st.ext)}};
    end
    else
    begin
      next_st.p4Out = portLat4;
      next_st.p4Oe  = {8{mode == `EMB_MODE_SC_OUT}};
    end
    next_st.p5Out = (p5Mask & next_st.addr[15:8]) | (~p5Mask & portLat5);
    next_st.p5Oe  = p5Mask | (~p5Mask & portDir5);
    p6Bus         = {next_st.address_latch_strobe, 1'b1, next_st.wrN, next_st.rdN, 4'h0};
    next_st.p6Out = (p6Mask & p6Bus) | (~p6Mask & portLat6);
    next_st.p6Oe  = (p6Mask & `EMB_P6_BUS_OE) | (~p6Mask & portDir6);
  end

  always_comb
  begin
    unique case (mode)
      `EMB_MODE_W4K:  p5Mask = `EMB_P5_4K;
      `EMB_MODE_W16K: p5Mask = `EMB_P5_16K;
      `EMB_MODE_FULL: p5Mask = `EMB_P5_FULL;
      default:        p5Mask = 8'h00;
    endcase
    p6Mask = expOn ? {1'b1, extWait, 2'b11, 4'h0} : 8'h00;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st <= RST_ST;
    else
      st <= next_st;
  end

  assign awready      = st.awReady;
  assign wready       = st.wReady;
  assign bvalid       = st.bValid;
  assign bresp        = st.bResp;
  assign arready      = st.arReady;
  assign rvalid       = st.rValid;
  assign rdata        = {24'h000000, st.rData};
  assign rresp        = st.rResp;
  assign cpuRsp.ack   = st.cpuAck;
  assign cpuRsp.rdata = st.cpuRdata;
  assign pin4Out      = st.p4Out;
  assign pin4Oe       = st.p4Oe;
  assign pin5Out      = st.p5Out;
  assign pin5Oe       = st.p5Oe;
  assign pin6Out      = st.p6Out;
  assign pin6Oe       = st.p6Oe;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  logic strobe;
  assign strobe = !(st.rdN && st.wrN);

  a_rd_internal_hi: assert property (!st.ext |-> st.rdN)
    else $error("Read strobe active on internal access.");
  a_wr_internal_hi: assert property (!st.ext |-> st.wrN)
    else $error("Write strobe active on internal access.");
  a_wr_no_fetch: assert property (st.fetch |-> st.wrN)
    else $error("Write strobe active during fetch.");
  a_rd_on_read: assert property (
    (st.phase == EMB_ADDR && st.ext && !st.write) |=> !st.rdN)
    else $error("Read strobe missing on external read.");
  a_address_latch_strobe_each_cycle: assert property (
    (st.phase == EMB_IDLE && cpuReq.valid) |=> st.address_latch_strobe ##1 !st.address_latch_strobe)
    else $error("Latch strobe not pulsed for one cycle.");
  a_no_wait_len: assert property (
    ($rose(strobe) && waitSel == `EMB_WAIT_NONE) |=> !strobe)
    else $error("Strobe longer than one cycle with no wait.");
  a_one_wait_len: assert property (
    ($rose(strobe) && waitSel == `EMB_WAIT_ONE) |-> strobe[*2] ##1 !strobe)
    else $error("Strobe not exactly two cycles with one wait.");
  a_ext_wait_hold: assert property (
    (strobe && !st.waitCnt && extWait && !pin6In[`EMB_P6_WAIT_BIT])
    |=> strobe)
    else $error("Strobe released while wait input low.");
  a_int_no_wait: assert property (
    (st.phase == EMB_STRB && !st.ext && !st.waitCnt) |=> st.phase == EMB_END)
    else $error("Internal access stretched by wait input.");
  a_p6_low_port: assert property (
    $past(resetn) |-> (pin6Out[3:0] == $past(portLat6[3:0]) &&
                       pin6Oe[3:0] == $past(portDir6[3:0])))
    else $error("Port six low nibble left port mode.");
  a_ack_after_cycle: assert property (
    (st.phase == EMB_IDLE && cpuReq.valid) |-> ##[3:400] st.cpuAck)
    else $error("Bus cycle did not complete.");

  // Pins are registered, so pin checks look one cycle back at the mode.
  a_p4_input_dir: assert property (
    ($past(resetn) && $past(mode == `EMB_MODE_SC_IN)) |-> pin4Oe == 8'h00)
    else $error("Port four driven in single-chip input mode.");
  a_upper_full_drive: assert property (
    ($past(resetn) && $past(mode == `EMB_MODE_FULL)) |-> pin5Oe == 8'hFF)
    else $error("Upper address lines not driven in full mode.");
  a_wait_pin_input: assert property (
    ($past(resetn) && $past(expOn && extWait))
    |-> !pin6Oe[`EMB_P6_WAIT_BIT])
    else $error("Wait pin driven while external wait is used.");
  a_addr_on_latch: assert property (
    (pin6Oe[7] && pin6Out[7]) |-> (pin4Oe == 8'hFF &&
                                   pin4Out == st.addr[7:0]))
    else $error("Low address not driven while latch strobe high.");
  a_fetch_reads: assert property (
    (st.phase == EMB_ADDR && st.ext && st.fetch) |=> !st.rdN)
    else $error("Read strobe missing on external fetch.");
  a_wr_on_write: assert property (
    (st.phase == EMB_ADDR && st.ext && st.write) |=> !st.wrN)
    else $error("Write strobe missing on external write.");
  a_strobes_exclusive: assert property (st.rdN || st.wrN)
    else $error("Read and write strobes active together.");

  c_ext_read: cover property (!st.rdN ##1 st.rdN);
  c_ext_write: cover property (!st.wrN ##1 st.wrN);
  c_ext_wait: cover property (strobe && extWait && !pin6In[6] ##1 strobe);
  c_internal: cover property (st.phase == EMB_STRB && !st.ext);
  c_fetch_ext: cover property (st.fetch && !st.rdN);
endmodule // emb_bus_ctrl

// file: bench/emb_ext_mem.sv
// Behavioural external memory on the far side of the expansion bus.
`timescale 1ns/1ns
module emb_ext_mem
(
  // Clock.
  input  wire logic       clk,
  // Bus pins from the controller.
  input  wire logic [7:0] pin4Out,
  input  wire logic [7:0] pin5Out,
  input  wire logic [7:0] pin5Oe,
  input  wire logic [7:0] pin6Out,
  input  wire logic [7:0] pin6Oe,
  // Wait stretch commanded by the bench.
  input  wire logic [3:0] waitLen,
  input  wire logic       holdWait,
  // Pins back to the controller.
  output logic [7:0]      pin4In,
  output logic [7:0]      pin6In
);
  logic [7:0]  mem [0:65535];
  logic [15:0] latAddr;
  logic [3:0]  waitCnt;
  logic [7:0]  lastOut;
  logic        rdAct;
  logic        wrAct;
  assign rdAct = pin6Oe[4] && !pin6Out[4];
  assign wrAct = pin6Oe[5] && !pin6Out[5];
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    latAddr = 16'h0000;
    waitCnt = 4'h0;
    lastOut = 8'h00;
  end
  // Address is taken while the latch strobe is high.
  always @(posedge clk)
  begin
    if (pin6Oe[7] && pin6Out[7])
      latAddr <= {pin5Out & pin5Oe, pin4Out};
    if (wrAct)
      mem[latAddr] <= pin4Out;
    if (rdAct)
      lastOut <= mem[latAddr];
    waitCnt <= (rdAct || wrAct) ? waitCnt + 4'h1 : 4'h0;
  end
  // A released bus shows the inverse of the last value, not a stale copy.
  assign pin4In = rdAct ? mem[latAddr] : ~lastOut;
  // Wait is held low for waitLen cycles of each strobe.
  assign pin6In = {1'b1,
                   !(holdWait || ((rdAct || wrAct) && waitCnt < waitLen)),
                   6'h3F};
endmodule // emb_ext_mem

// file: bench/test_emb_bus_ctrl.sv
// Self-checking testbench of the expansion bus controller.
`timescale 1ns/1ns
module test_emb_bus_ctrl;
  import emb_pkg::*;
  logic clk = 1'b0, resetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, waitLen = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, holdWait = 1'b0;
  logic [1:0] bresp, rresp, rr;
  emb_cpu_req_t cpuReq = '0;
  emb_cpu_rsp_t cpuRsp;
  logic [7:0] portLat4 = 8'h3C, portLat5 = 8'h00, portDir5 = 8'h00;
  logic [7:0] portLat6 = 8'h00, portDir6 = 8'h4A;
  logic [7:0] pin4In, pin6In, pin4Out, pin4Oe, pin5Out, pin5Oe;
  logic [7:0] pin6Out, pin6Oe, rdv, p5v, p5m;
  logic [31:0] rv;
  int mismatches = 0, cmp_count = 0, cyc, nAstb, nRd, nWr;
  always #5 clk = ~clk;
  emb_bus_ctrl emb_bus_ctrl_i (.clk(clk), .resetn(resetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cpuReq(cpuReq), .cpuRsp(cpuRsp), .portLat4(portLat4),
    .portLat5(portLat5), .portDir5(portDir5), .portLat6(portLat6),
    .portDir6(portDir6), .pin4In(pin4In), .pin6In(pin6In),
    .pin4Out(pin4Out), .pin4Oe(pin4Oe), .pin5Out(pin5Out),
    .pin5Oe(pin5Oe), .pin6Out(pin6Out), .pin6Oe(pin6Oe));
  emb_ext_mem emb_ext_mem_i (.clk(clk), .pin4Out(pin4Out),
    .pin5Out(pin5Out), .pin5Oe(pin5Oe), .pin6Out(pin6Out),
    .pin6Oe(pin6Oe), .waitLen(waitLen), .holdWait(holdWait),
    .pin4In(pin4In), .pin6In(pin6In));
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Register write; both channels offered together, held until taken.
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    rr = bresp;
    chk("write answer", 1, n < 50);
  endtask
  task automatic axi_rd(input logic [15:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rv = rdata;
    rr = rresp;
    chk("read answer", 1, n < 50);
  endtask
  // One CPU access; counts strobe cycles seen until the acknowledge.
  task automatic cpu(input logic f, input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    cpuReq <= '{valid: 1'b1, fetch: f, write: w, addr: a, wdata: d};
    cyc = 0;
    nAstb = 0;
    nRd = 0;
    nWr = 0;
    while (cyc < 40)
    begin
      @(posedge clk);
      cyc++;
      if (pin6Oe[7] && pin6Out[7])
      begin
        nAstb++;
        p5v = pin5Out;
        p5m = pin5Oe;
      end
      if (pin6Oe[4] && !pin6Out[4])
        nRd++;
      if (pin6Oe[5] && !pin6Out[5])
        nWr++;
      if (cpuRsp.ack === 1'b1)
        break;
    end
    rdv = cpuRsp.rdata;
    cpuReq.valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs;
    axi_rd(16'hFFF8);
    chk("mode reset", 32'h10, rv);
    axi_rd(16'hFFF0);
    chk("size reset", 32'hC8, rv);
    axi_wr(16'hFFF8, 8'hFF);
    axi_rd(16'hFFF8);
    chk("mode fields", 32'h37, rv);
    axi_wr(16'hFFF0, 8'hFF);
    axi_rd(16'hFFF0);
    chk("size fields", 32'hEF, rv);
    axi_wr(16'hFFF0, 8'hC8);
    chk("write resp", 2'h0, rr);
    axi_wr(16'h1234, 8'h00);
    chk("unmapped wr resp", 2'h2, rr);
    axi_rd(16'h1234);
    chk("unmapped resp", 2'h2, rr);
  endtask
  task automatic t_wait;
    logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
    int lat [3] = '{3, 4, 6};
    waitLen <= 4'h3;
    for (int i = 0; i < 3; i++)
    begin
      axi_wr(16'hFFF8, {2'b00, code[i], 4'h7});
      cpu(i == 2, 1'b0, 16'h8123, 8'h00);
      chk("ack time", lat[i] + 1, cyc);
      chk("read strobe", lat[i] - 2, nRd);
      chk("latch pulses", 1, nAstb);
      chk("read data", pat(16'h8123), rdv);
      chk("wait pin oe", i != 2, pin6Oe[6]);
    end
    waitLen <= 4'h0;
  endtask
  task automatic t_write;
    axi_wr(16'hFFF8, 8'h07);
    cpu(1'b0, 1'b1, 16'h8200, 8'hA5);
    chk("write strobe", 1, nWr);
    chk("stored", 8'hA5, emb_ext_mem_i.mem[16'h8200]);
    cpu(1'b0, 1'b0, 16'h8200, 8'h00);
    chk("rmw read", 8'hA5, rdv);
    cpu(1'b1, 1'b1, 16'h8200, 8'h11);
    chk("fetch write", 0, nWr);
    chk("fetch read", 1, nRd);
  endtask
  task automatic t_internal;
    axi_wr(16'hFFF8, 8'h37);
    holdWait <= 1'b1;
    cpu(1'b0, 1'b0, 16'h0100, 8'h00);
    chk("int ack", 4, cyc);
    chk("int read strobe", 0, nRd);
    chk("int latch", 1, nAstb);
    cpu(1'b0, 1'b1, 16'h0100, 8'h66);
    chk("int write strobe", 0, nWr);
    holdWait <= 1'b0;
  endtask
  task automatic t_ports;
    logic [2:0] md [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
    logic [7:0] mk [4] = '{8'h00, 8'h0F, 8'h3F, 8'hFF};
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(16'hFFF8, {5'h00, md[i]});
      cpu(1'b0, 1'b0, 16'h8023, 8'h00);
      chk("upper oe", mk[i], p5m);
      chk("upper addr", 8'h80 & mk[i], p5v & mk[i]);
      chk("mode data", pat({8'h80 & mk[i], 8'h23}), rdv);
      chk("p6 low", portDir6[3:0], pin6Oe[3:0]);
    end
    for (int i = 0; i < 2; i++)
    begin
      axi_wr(16'hFFF8, 8'(i));
      repeat (2) @(posedge clk);
      chk("p4 dir", i ? 8'hFF : 8'h00, pin4Oe);
    end
  endtask
  task automatic t_rom60;
    axi_wr(16'hFFF8, 8'h07);
    axi_wr(16'hFFF0, 8'hCF);
    cpu(1'b0, 1'b0, 16'hF123, 8'h00);
    chk("rom60 hole", 0, nRd);
    axi_wr(16'hFFF0, 8'hCE);
    cpu(1'b0, 1'b0, 16'hF123, 8'h00);
    chk("rom56 ext", 1, nRd);
    chk("rom56 data", pat(16'hF123), rdv);
  endtask
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_wait();
    t_write();
    t_internal();
    t_ports();
    t_rom60();
    complete_run();
  end
endmodule // test_emb_bus_ctrl
